/* core/cef_flags.sv */
// Notes on behaviour
// [R1] Flag registers at 0x24, 0x25, 0x26; reset zero
// [R2] Bit 6 set when port detection finishes
// [R3] Bit 5 conversion done, single mode only
// [R4] Bit 4 set entering or leaving minimum-system regulation
// [R5] Bit 3 set on fast timer expiry rise
// [R6] Bit 2 set on trickle timer expiry rise
// [R7] Bit 1 set on precharge timer expiry rise
// [R8] Bit 0 set on topoff timer expiry rise
// [R9] Thermistor bits 7-4 zero; bit 3 cold crossing
// [R10] Thermistor bit 2 set on cool crossing
// [R11] Thermistor bit 1 set on warm crossing
// [R12] Thermistor bit 0 set on hot crossing
// [R13] Protection bit 7 on battery-current regulation change
// [R14] Protection bit 3 on discharge over-current entry
// [R15] Protection bit 2 on converter over-current entry
// [R16] Protection bits 6,5,4,1 on their protection entries
// [R17] Reading a register clears it; new events win
module cef_flags (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic port_detect_done,
  input wire logic adc_conv_done,
  input wire logic adc_single_mode,
  input wire logic min_sys_reg_active,
  input wire logic fast_timer_expired,
  input wire logic trickle_timer_expired,
  input wire logic precharge_timer_expired,
  input wire logic topoff_timer_expired,
  input wire logic therm_cold,
  input wire logic therm_cool,
  input wire logic therm_warm,
  input wire logic therm_hot,
  input wire logic batt_current_reg_active,
  input wire logic bus_overvoltage,
  input wire logic batt_overvoltage,
  input wire logic bus_overcurrent,
  input wire logic batt_discharge_overcurrent,
  input wire logic converter_overcurrent,
  input wire logic second_input_overvoltage,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid
);

  // Rising edge of a synchronised level
  function automatic logic rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // Any change of a synchronised level
  function automatic logic moved(input logic cur, input logic prev);
    return cur ^ prev;
  endfunction

  logic [cef_pkg::CEF_NSRC-1:0] raw;
  logic [cef_pkg::CEF_NSRC-1:0] sync1_ff;
  logic [cef_pkg::CEF_NSRC-1:0] sync2_ff;
  logic [cef_pkg::CEF_NSRC-1:0] prev_ff;
  logic [7:0] chg_flags_ff;
  logic [7:0] therm_flags_ff;
  logic [7:0] prot_flags_ff;
  logic [7:0] nxt_chg_flags;
  logic [7:0] nxt_therm_flags;
  logic [7:0] nxt_prot_flags;
  logic [7:0] chg_set;
  logic [7:0] therm_set;
  logic [7:0] prot_set;
  logic [7:0] rd_data_ff;
  logic rd_valid_ff;
  logic rd_chg;
  logic rd_therm;
  logic rd_prot;

  // Gather analog-side levels into one vector
  assign raw = {second_input_overvoltage, converter_overcurrent, batt_discharge_overcurrent,
                bus_overcurrent, batt_overvoltage, bus_overvoltage, batt_current_reg_active,
                therm_hot, therm_warm, therm_cool, therm_cold, topoff_timer_expired,
                precharge_timer_expired, trickle_timer_expired, fast_timer_expired,
                min_sys_reg_active, adc_single_mode, adc_conv_done, port_detect_done};

  // Two-stage synchroniser; analog side is not on clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
    end
  end

  // Previous synchronised value for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= sync2_ff;
    end
  end

  // Set terms of the first charger flag register
  always_comb begin
    chg_set = 8'h00;
    chg_set[cef_pkg::CEF_B_PORT_DET] = rose(sync2_ff[cef_pkg::CEF_S_PORT_DET],
                                            prev_ff[cef_pkg::CEF_S_PORT_DET]); // [R2]
    chg_set[cef_pkg::CEF_B_CONV_DONE] = rose(sync2_ff[cef_pkg::CEF_S_CONV_DONE],
                                             prev_ff[cef_pkg::CEF_S_CONV_DONE])
                                        & sync2_ff[cef_pkg::CEF_S_SINGLE]; // [R3]
    chg_set[cef_pkg::CEF_B_MIN_SYS] = moved(sync2_ff[cef_pkg::CEF_S_MIN_SYS],
                                            prev_ff[cef_pkg::CEF_S_MIN_SYS]); // [R4]
    chg_set[cef_pkg::CEF_B_FAST_TMR] = rose(sync2_ff[cef_pkg::CEF_S_FAST],
                                            prev_ff[cef_pkg::CEF_S_FAST]); // [R5]
    chg_set[cef_pkg::CEF_B_TRICKLE_TMR] = rose(sync2_ff[cef_pkg::CEF_S_TRICKLE],
                                               prev_ff[cef_pkg::CEF_S_TRICKLE]); // [R6]
    chg_set[cef_pkg::CEF_B_PRECHG_TMR] = rose(sync2_ff[cef_pkg::CEF_S_PRECHG],
                                              prev_ff[cef_pkg::CEF_S_PRECHG]); // [R7]
    chg_set[cef_pkg::CEF_B_TOPOFF_TMR] = rose(sync2_ff[cef_pkg::CEF_S_TOPOFF],
                                              prev_ff[cef_pkg::CEF_S_TOPOFF]); // [R8]
  end

  // Thermistor crossings count in either direction
  always_comb begin
    therm_set = 8'h00; // [R9]
    therm_set[cef_pkg::CEF_B_COLD] = moved(sync2_ff[cef_pkg::CEF_S_COLD],
                                           prev_ff[cef_pkg::CEF_S_COLD]); // [R9]
    therm_set[cef_pkg::CEF_B_COOL] = moved(sync2_ff[cef_pkg::CEF_S_COOL],
                                           prev_ff[cef_pkg::CEF_S_COOL]); // [R10]
    therm_set[cef_pkg::CEF_B_WARM] = moved(sync2_ff[cef_pkg::CEF_S_WARM],
                                           prev_ff[cef_pkg::CEF_S_WARM]); // [R11]
    therm_set[cef_pkg::CEF_B_HOT] = moved(sync2_ff[cef_pkg::CEF_S_HOT],
                                          prev_ff[cef_pkg::CEF_S_HOT]); // [R12]
  end

  // Protection entries, and battery-current regulation on any change; bit 0 belongs to another block and reads zero
  always_comb begin
    prot_set = 8'h00;
    prot_set[cef_pkg::CEF_B_BATT_IREG] = moved(sync2_ff[cef_pkg::CEF_S_IREG],
                                               prev_ff[cef_pkg::CEF_S_IREG]); // [R13]
    prot_set[cef_pkg::CEF_B_BATT_OCP] = rose(sync2_ff[cef_pkg::CEF_S_BATT_OCP],
                                             prev_ff[cef_pkg::CEF_S_BATT_OCP]); // [R14]
    prot_set[cef_pkg::CEF_B_CONV_OCP] = rose(sync2_ff[cef_pkg::CEF_S_CONV_OCP],
                                             prev_ff[cef_pkg::CEF_S_CONV_OCP]); // [R15]
    prot_set[cef_pkg::CEF_B_BUS_OVP] = rose(sync2_ff[cef_pkg::CEF_S_BUS_OVP],
                                            prev_ff[cef_pkg::CEF_S_BUS_OVP]); // [R16]
    prot_set[cef_pkg::CEF_B_BATT_OVP] = rose(sync2_ff[cef_pkg::CEF_S_BATT_OVP],
                                             prev_ff[cef_pkg::CEF_S_BATT_OVP]); // [R16]
    prot_set[cef_pkg::CEF_B_BUS_OCP] = rose(sync2_ff[cef_pkg::CEF_S_BUS_OCP],
                                            prev_ff[cef_pkg::CEF_S_BUS_OCP]); // [R16]
    prot_set[cef_pkg::CEF_B_IN2_OVP] = rose(sync2_ff[cef_pkg::CEF_S_IN2_OVP],
                                            prev_ff[cef_pkg::CEF_S_IN2_OVP]); // [R16]
  end

  // Address decode of a read
  assign rd_chg = rd_en & (rd_addr == cef_pkg::CEF_OFS_CHG); // [R1]
  assign rd_therm = rd_en & (rd_addr == cef_pkg::CEF_OFS_THERM); // [R1]
  assign rd_prot = rd_en & (rd_addr == cef_pkg::CEF_OFS_PROT); // [R1]

  // Clear on read, but a same-cycle event survives the clear
  always_comb begin
    nxt_chg_flags = (rd_chg ? 8'h00 : chg_flags_ff) | chg_set; // [R17]
    nxt_therm_flags = (rd_therm ? 8'h00 : therm_flags_ff) | therm_set; // [R17]
    nxt_prot_flags = (rd_prot ? 8'h00 : prot_flags_ff) | prot_set; // [R17]
    // Detection restarting means not done any more, even if it just finished
    if (rose(prev_ff[cef_pkg::CEF_S_PORT_DET], sync2_ff[cef_pkg::CEF_S_PORT_DET])) begin
      nxt_chg_flags[cef_pkg::CEF_B_PORT_DET] = 1'b0; // [R2]
    end
  end

  // Flag storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_flags_ff <= cef_pkg::CEF_FLAGS_RESET; // [R1]
      therm_flags_ff <= cef_pkg::CEF_FLAGS_RESET; // [R1]
      prot_flags_ff <= cef_pkg::CEF_FLAGS_RESET; // [R1]
    end else begin
      chg_flags_ff <= nxt_chg_flags & cef_pkg::CEF_CHG_USED;
      therm_flags_ff <= nxt_therm_flags & cef_pkg::CEF_THERM_USED; // [R9]
      prot_flags_ff <= nxt_prot_flags & cef_pkg::CEF_PROT_USED;
    end
  end

  // Read data is captured with the pre-clear value; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_en;
      if (rd_chg) begin
        rd_data_ff <= chg_flags_ff; // [R1]
      end else if (rd_therm) begin
        rd_data_ff <= therm_flags_ff; // [R1]
      end else if (rd_prot) begin
        rd_data_ff <= prot_flags_ff; // [R1]
      end else if (rd_en) begin
        rd_data_ff <= 8'h00;
      end
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;

  // Checks on the flag behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_DETECT_DONE_SETS: assert property ( // [R2]
    $rose(sync2_ff[cef_pkg::CEF_S_PORT_DET]) |=> chg_flags_ff[cef_pkg::CEF_B_PORT_DET])
    else $error("port detect flag not set after detection finished");

  AST_CONV_DONE_SINGLE_ONLY: assert property ( // [R3]
    $rose(chg_flags_ff[cef_pkg::CEF_B_CONV_DONE])
      |-> $past(sync2_ff[cef_pkg::CEF_S_SINGLE]) && $past(sync2_ff[cef_pkg::CEF_S_CONV_DONE]))
    else $error("conversion flag set outside single mode");

  AST_MIN_SYS_BOTH_EDGES: assert property ( // [R4]
    (sync2_ff[cef_pkg::CEF_S_MIN_SYS] != prev_ff[cef_pkg::CEF_S_MIN_SYS])
      |=> chg_flags_ff[cef_pkg::CEF_B_MIN_SYS])
    else $error("minimum system regulation change not flagged");

  AST_FAST_TIMER_RISE: assert property ( // [R5]
    $rose(chg_flags_ff[cef_pkg::CEF_B_FAST_TMR])
      |-> $past(sync2_ff[cef_pkg::CEF_S_FAST]) && !$past(prev_ff[cef_pkg::CEF_S_FAST]))
    else $error("fast timer flag set without expiry rise");

  AST_TOPOFF_TIMER_RISE: assert property ( // [R8]
    (sync2_ff[cef_pkg::CEF_S_TOPOFF] && !prev_ff[cef_pkg::CEF_S_TOPOFF])
      |=> chg_flags_ff[cef_pkg::CEF_B_TOPOFF_TMR])
    else $error("topoff timer flag missed");

  AST_THERM_RESERVED_ZERO: assert property ( // [R9]
    (therm_flags_ff & ~cef_pkg::CEF_THERM_USED) == 8'h00)
    else $error("thermistor reserved bits not zero");

  AST_HOT_CROSSING: assert property ( // [R12]
    $changed(sync2_ff[cef_pkg::CEF_S_HOT]) ##1 1'b1 |-> therm_flags_ff[cef_pkg::CEF_B_HOT])
    else $error("hot crossing not flagged");

  AST_CONV_OCP_ENTRY: assert property ( // [R15]
    (sync2_ff[cef_pkg::CEF_S_CONV_OCP] && !prev_ff[cef_pkg::CEF_S_CONV_OCP])
      |=> prot_flags_ff[cef_pkg::CEF_B_CONV_OCP] [*1]
          ##0 ((prot_flags_ff & ~cef_pkg::CEF_PROT_USED) == 8'h00))
    else $error("converter over-current entry not flagged");

  AST_READ_RETURNS_AND_CLEARS: assert property ( // [R17]
    (rd_prot && prot_set == 8'h00)
      |=> rd_valid && rd_data == $past(prot_flags_ff) && prot_flags_ff == 8'h00)
    else $error("protection read did not return then clear");

  AST_FLAG_HOLDS_UNTIL_READ: assert property ( // [R17]
    (chg_flags_ff[cef_pkg::CEF_B_PRECHG_TMR] && !rd_chg)
      |=> chg_flags_ff[cef_pkg::CEF_B_PRECHG_TMR])
    else $error("precharge flag dropped without a read");

  AST_TRICKLE_TIMER_RISE: assert property ( // [R6]
    (sync2_ff[cef_pkg::CEF_S_TRICKLE] && !prev_ff[cef_pkg::CEF_S_TRICKLE])
      |=> chg_flags_ff[cef_pkg::CEF_B_TRICKLE_TMR])
    else $error("trickle timer flag missed");

  AST_PRECHG_TIMER_RISE: assert property ( // [R7]
    $rose(chg_flags_ff[cef_pkg::CEF_B_PRECHG_TMR])
      |-> $past(sync2_ff[cef_pkg::CEF_S_PRECHG]) && !$past(prev_ff[cef_pkg::CEF_S_PRECHG]))
    else $error("precharge timer flag set without expiry rise");

  AST_COLD_CROSSING: assert property ( // [R9]
    (sync2_ff[cef_pkg::CEF_S_COLD] != prev_ff[cef_pkg::CEF_S_COLD])
      |=> therm_flags_ff[cef_pkg::CEF_B_COLD])
    else $error("cold crossing not flagged");

  AST_COOL_CROSSING: assert property ( // [R10]
    (sync2_ff[cef_pkg::CEF_S_COOL] != prev_ff[cef_pkg::CEF_S_COOL])
      |=> therm_flags_ff[cef_pkg::CEF_B_COOL])
    else $error("cool crossing not flagged");

  AST_WARM_CROSSING: assert property ( // [R11]
    (sync2_ff[cef_pkg::CEF_S_WARM] != prev_ff[cef_pkg::CEF_S_WARM])
      |=> therm_flags_ff[cef_pkg::CEF_B_WARM])
    else $error("warm crossing not flagged");

  AST_IREG_BOTH_EDGES: assert property ( // [R13]
    (sync2_ff[cef_pkg::CEF_S_IREG] != prev_ff[cef_pkg::CEF_S_IREG])
      |=> prot_flags_ff[cef_pkg::CEF_B_BATT_IREG])
    else $error("battery current regulation change not flagged");

  AST_BATT_OCP_ENTRY: assert property ( // [R14]
    (sync2_ff[cef_pkg::CEF_S_BATT_OCP] && !prev_ff[cef_pkg::CEF_S_BATT_OCP])
      |=> prot_flags_ff[cef_pkg::CEF_B_BATT_OCP])
    else $error("discharge over-current entry not flagged");

  AST_BUS_OVP_ENTRY_ONLY: assert property ( // [R16]
    $rose(prot_flags_ff[cef_pkg::CEF_B_BUS_OVP])
      |-> $past(sync2_ff[cef_pkg::CEF_S_BUS_OVP]) && !$past(prev_ff[cef_pkg::CEF_S_BUS_OVP]))
    else $error("bus over-voltage flag set without an entry");

  AST_IN2_OVP_ENTRY: assert property ( // [R16]
    (sync2_ff[cef_pkg::CEF_S_IN2_OVP] && !prev_ff[cef_pkg::CEF_S_IN2_OVP])
      |=> prot_flags_ff[cef_pkg::CEF_B_IN2_OVP])
    else $error("second input over-voltage entry not flagged");

  AST_DETECT_RESTART_CLEARS: assert property ( // [R2]
    (prev_ff[cef_pkg::CEF_S_PORT_DET] && !sync2_ff[cef_pkg::CEF_S_PORT_DET])
      |=> !chg_flags_ff[cef_pkg::CEF_B_PORT_DET])
    else $error("port detect flag kept after detection restarted");

endmodule // cef_flags

/* core/cef_pkg.sv */
package cef_pkg;
  // Register offsets on the register map
  localparam logic [7:0] CEF_OFS_CHG = 8'h24;
  localparam logic [7:0] CEF_OFS_THERM = 8'h25;
  localparam logic [7:0] CEF_OFS_PROT = 8'h26;
  localparam logic [7:0] CEF_FLAGS_RESET = 8'h00;

  // Bit positions, first charger flag register
  localparam int CEF_B_PORT_DET = 6;
  localparam int CEF_B_CONV_DONE = 5;
  localparam int CEF_B_MIN_SYS = 4;
  localparam int CEF_B_FAST_TMR = 3;
  localparam int CEF_B_TRICKLE_TMR = 2;
  localparam int CEF_B_PRECHG_TMR = 1;
  localparam int CEF_B_TOPOFF_TMR = 0;

  // Bit positions, thermistor flag register
  localparam int CEF_B_COLD = 3;
  localparam int CEF_B_COOL = 2;
  localparam int CEF_B_WARM = 1;
  localparam int CEF_B_HOT = 0;
  localparam logic [7:0] CEF_THERM_USED = 8'h0f;

  // Bit positions, protection flag register
  localparam int CEF_B_BATT_IREG = 7;
  localparam int CEF_B_BUS_OVP = 6;
  localparam int CEF_B_BATT_OVP = 5;
  localparam int CEF_B_BUS_OCP = 4;
  localparam int CEF_B_BATT_OCP = 3;
  localparam int CEF_B_CONV_OCP = 2;
  localparam int CEF_B_IN2_OVP = 1;
  localparam logic [7:0] CEF_PROT_USED = 8'hfe;
  localparam logic [7:0] CEF_CHG_USED = 8'h7f;

  // Index of each source in the synchronised source vector
  localparam int CEF_NSRC = 19;
  localparam int CEF_S_PORT_DET = 0;
  localparam int CEF_S_CONV_DONE = 1;
  localparam int CEF_S_SINGLE = 2;
  localparam int CEF_S_MIN_SYS = 3;
  localparam int CEF_S_FAST = 4;
  localparam int CEF_S_TRICKLE = 5;
  localparam int CEF_S_PRECHG = 6;
  localparam int CEF_S_TOPOFF = 7;
  localparam int CEF_S_COLD = 8;
  localparam int CEF_S_COOL = 9;
  localparam int CEF_S_WARM = 10;
  localparam int CEF_S_HOT = 11;
  localparam int CEF_S_IREG = 12;
  localparam int CEF_S_BUS_OVP = 13;
  localparam int CEF_S_BATT_OVP = 14;
  localparam int CEF_S_BUS_OCP = 15;
  localparam int CEF_S_BATT_OCP = 16;
  localparam int CEF_S_CONV_OCP = 17;
  localparam int CEF_S_IN2_OVP = 18;
endpackage

/* test/cef_flags_tb.sv */
module cef_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic rst_n;
  logic [18:0] src;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_valid;
  int num_errors;
  int checked;
  int cycles = 0;

  cef_flags dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .port_detect_done(src[0]),
    .adc_conv_done(src[1]),
    .adc_single_mode(src[2]),
    .min_sys_reg_active(src[3]),
    .fast_timer_expired(src[4]),
    .trickle_timer_expired(src[5]),
    .precharge_timer_expired(src[6]),
    .topoff_timer_expired(src[7]),
    .therm_cold(src[8]),
    .therm_cool(src[9]),
    .therm_warm(src[10]),
    .therm_hot(src[11]),
    .batt_current_reg_active(src[12]),
    .bus_overvoltage(src[13]),
    .batt_overvoltage(src[14]),
    .bus_overcurrent(src[15]),
    .batt_discharge_overcurrent(src[16]),
    .converter_overcurrent(src[17]),
    .second_input_overvoltage(src[18]),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_valid(rd_valid)
  );

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // One read strobe; answer checked mid-cycle, return on an edge for the next drive
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, e);
    @(posedge clk);
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Register and bit mask of each event source except conversion done, in source-vector order
  function automatic logic [7:0] loc(input int i);
    return (i < 8) ? 8'h24 : (i < 12) ? 8'h25 : 8'h26;
  endfunction

  function automatic logic [7:0] msk(input int i);
    if (i == 0) return 8'h40;
    if (i < 8) return 8'h01 << (7 - i);
    if (i < 12) return 8'h01 << (11 - i);
    return 8'h01 << (19 - i);
  endfunction

  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end

  // One source alone: set, hold, drop; falling edge only counts for toggle flags
  task automatic pulse(input int i);
    bit both;
    both = (i == 3) || (i >= 8 && i <= 12);
    src[i] <= 1'b1;
    gap(4);
    rd(loc(i), msk(i));
    rd(loc(i), 8'h00);
    src[i] <= 1'b0;
    gap(4);
    rd(loc(i), both ? msk(i) : 8'h00);
    rd(loc(i), 8'h00);
  endtask

  initial begin
    rst_n = 1'b0;
    src = '0;
    rd_en = 1'b0;
    rd_addr = 8'h00;
    num_errors = 0;
    checked = 0;
    gap(3);
    rst_n <= 1'b1;
    gap(4);
    rd(8'h24, 8'h00);
    rd(8'h25, 8'h00);
    rd(8'h26, 8'h00);
    rd(8'h27, 8'h00);
    // Sources one at a time, register by register; conversion inputs come later
    for (int i = 0; i < 8; i++) begin
      if (i != 1 && i != 2) begin
        pulse(i);
      end
    end
    for (int i = 8; i < 12; i++) begin
      pulse(i);
    end
    for (int i = 12; i < 19; i++) begin
      pulse(i);
    end
    // Conversion flag ignored outside single-conversion mode
    src[1] <= 1'b1;
    gap(4);
    src[1] <= 1'b0;
    gap(4);
    rd(8'h24, 8'h00);
    src[2] <= 1'b1;
    gap(4);
    src[1] <= 1'b1;
    gap(4);
    rd(8'h24, 8'h20);
    // Drop the conversion level so the all-ones step makes a fresh rise
    src[1] <= 1'b0;
    gap(4);
    // Detection restarting takes the done flag back down without a read
    src[0] <= 1'b1;
    gap(4);
    src[0] <= 1'b0;
    gap(4);
    rd(8'h24, 8'h00);
    // All sources at once: reserved bits must stay clear
    src <= '1;
    gap(4);
    rd(8'h24, 8'h7f);
    rd(8'h25, 8'h0f);
    rd(8'h26, 8'hfe);
    src <= 19'h00004;
    gap(4);
    rd(8'h24, 8'h10);
    rd(8'h25, 8'h0f);
    rd(8'h26, 8'h80);
    // Reset in mid-run wipes a pending flag and the last read data
    src[13] <= 1'b1;
    gap(4);
    rst_n <= 1'b0;
    src[13] <= 1'b0;
    gap(2);
    @(negedge clk);
    chk(rd_data, 8'h00);
    chk({7'h00, rd_valid}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    gap(4);
    rd(8'h26, 8'h00);
    results();
  end
endmodule // cef_flags_tb
